// [host_model.sv]
// Avalon-MM host model issuing register transfers
`timescale 1ns/10ps
`default_nettype none
module host_model
(
	input  wire logic                           clock,
	input  wire logic                           waitrequest,
	input  wire logic [liu_clk_pkg::DATA_W-1:0] readdata,
	output var  logic [liu_clk_pkg::ADDR_W-1:0] address,
	output var  logic                           read,
	output var  logic                           write,
	output var  logic [liu_clk_pkg::DATA_W-1:0] writedata,
	output var  logic [liu_clk_pkg::BE_W-1:0]   byteenable
);
	import liu_clk_pkg::*;
	initial
		{address, read, write, writedata, byteenable} <= '0;
	// Holds the request until waitrequest is seen low; no fixed latency assumed
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [BE_W-1:0] be, output logic [DATA_W-1:0] q);
		@(posedge clock);
		{address, writedata, byteenable, write, read} <= {a, d, be, w, !w};
		do
			@(posedge clock);
		while (waitrequest !== 1'h0);
		q = readdata;
		{read, write} <= 2'h0;
		writedata <= ~d; // Stale data never left looking valid
	endtask
endmodule
`default_nettype wire

// [liu_cfg_checker.sv]
// Assertion checker for the line clock configuration block
`timescale 1ns/10ps
`default_nettype none
module liu_cfg_checker
(
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        chan0_irq_in,
	input wire logic        master_clock_out_pin,
	input wire logic [15:0] in_rate_khz_out,
	input wire logic        in_rate_reserved
);
	logic       flag_r, ev_r, pin_r;
	logic [7:0] gap_r;
	wire        gis_rd = read && !waitrequest && address[7:2] == 6'h02;
	// Flag model; an event seen during the read is kept
	always_ff @(posedge clock or negedge rstn)
		if (!rstn)
			{flag_r, ev_r, pin_r, gap_r} <= 11'h000;
		else
		begin
			ev_r <= chan0_irq_in;
			pin_r <= master_clock_out_pin;
			gap_r <= (pin_r != master_clock_out_pin) ? 8'h00 : gap_r + 8'h01;
			flag_r <= chan0_irq_in || (flag_r && !(gis_rd && readdata[0] && !ev_r));
		end
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// Completed write of the input rate register
	sequence s_in_wr;
		write && !waitrequest && byteenable[0] && address[7:2] == 6'h01;
	endsequence
	property p_rsvd;
		logic [3:0] c;
		(s_in_wr, c = writedata[3:0]) |-> ##2 in_rate_reserved == (!c[3] && c[2:1] != 2'h0);
	endproperty
	// Reset values must show while reset is held
	property p_rst;
		disable iff (1'h0) !rstn |-> in_rate_khz_out == 16'h0608 && !master_clock_out_pin;
	endproperty
	a_req_answered: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low twice");
	a_no_stray: assert property (!(read || write) && waitrequest |=> waitrequest)
		else $error("answer without request");
	a_flag_value: assert property (gis_rd |-> readdata[0] == $past(flag_r))
		else $error("channel flag wrong");
	a_status_zero: assert property (gis_rd |-> readdata[31:1] == 31'h0)
		else $error("status upper bits set");
	a_rsvd_decode: assert property (p_rsvd)
		else $error("reserved flag wrong");
	a_reset_vals: assert property (p_rst)
		else $error("reset value wrong");
	a_pin_gap: assert property (gap_r <= 8'h0E)
		else $error("output clock stalled");
endmodule
bind liu_global_clock_irq_config liu_cfg_checker u_chk (.clock, .rstn, .address, .read, .write,
	.writedata, .byteenable, .readdata, .waitrequest, .chan0_irq_in, .master_clock_out_pin,
	.in_rate_khz_out, .in_rate_reserved);
`default_nettype wire

// [liu_clk_pkg.sv]
// Constants, types and decode functions for the line clock rate register block
`default_nettype none

package liu_clk_pkg;

	// Bus geometry: byte address, 32-bit data, one word per register
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_OUT_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_IN_CFG  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_GIS     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EVS     = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_EVC     = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_EVE     = 8'h14;

	// Field positions and widths
	localparam int CFG_W       = 8;
	localparam int OUT_RATE_LSB = 4;
	localparam int OUT_RATE_W   = 2;
	localparam int IN_RATE_LSB  = 0;
	localparam int IN_RATE_W    = 4;
	localparam int CHAN0_BIT    = 0;

	// Reset values
	localparam logic [CFG_W-1:0] OUT_CFG_RST = 8'h00;
	localparam logic [CFG_W-1:0] IN_CFG_RST  = 8'h01;

	// Event bits of the sticky event status register
	localparam int EVT_W       = 2;
	localparam int EVT_CHAN0   = 0;
	localparam int EVT_BAD_SEL = 1;

	// Rates in kHz; system clock is 40 MHz
	localparam logic [15:0] CLK_KHZ   = 16'h9C40;
	localparam logic [15:0] KHZ_1544  = 16'h0608;
	localparam logic [15:0] KHZ_2048  = 16'h0800;
	localparam logic [15:0] KHZ_3088  = 16'h0C10;
	localparam logic [15:0] KHZ_4096  = 16'h1000;
	localparam logic [15:0] KHZ_6176  = 16'h1820;
	localparam logic [15:0] KHZ_8192  = 16'h2000;
	localparam logic [15:0] KHZ_12352 = 16'h3040;
	localparam logic [15:0] KHZ_16384 = 16'h4000;
	localparam logic [15:0] KHZ_NONE  = 16'h0000;

	// Phase accumulator width for the output clock synthesiser
	localparam int NCO_W = 24;

	typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

	// Accumulator step: two toggles per output period
	function automatic logic [NCO_W-1:0] nco_inc(input logic [15:0] khz);
		logic [63:0] w;
		w = ({48'h0, khz} << (NCO_W + 1)) / {48'h0, CLK_KHZ};
		return w[NCO_W-1:0];
	endfunction

	localparam logic [NCO_W-1:0] INC_1544  = nco_inc(KHZ_1544);
	localparam logic [NCO_W-1:0] INC_3088  = nco_inc(KHZ_3088);
	localparam logic [NCO_W-1:0] INC_6176  = nco_inc(KHZ_6176);
	localparam logic [NCO_W-1:0] INC_12352 = nco_inc(KHZ_12352);

	// Input rate code to kHz; reserved codes give zero
	function automatic logic [15:0] in_rate_khz(input logic [IN_RATE_W-1:0] code);
		case (code)
			4'h0, 4'hE: return KHZ_2048;
			4'h1, 4'hF: return KHZ_1544;
			4'h8:       return KHZ_4096;
			4'h9:       return KHZ_3088;
			4'hA:       return KHZ_8192;
			4'hB:       return KHZ_6176;
			4'hC:       return KHZ_16384;
			4'hD:       return KHZ_12352;
			default:    return KHZ_NONE;
		endcase
	endfunction

endpackage

`default_nettype wire

// [liu_global_clock_irq_config.sv]
// Global line clock rate configuration and channel interrupt flag block
`timescale 1ns/10ps
`default_nettype none

module liu_global_clock_irq_config
(
	input  wire logic                              clock,
	input  wire logic                              rstn,
	input  wire logic [liu_clk_pkg::ADDR_W-1:0]    address,
	input  wire logic                              read,
	input  wire logic                              write,
	input  wire logic [liu_clk_pkg::DATA_W-1:0]    writedata,
	input  wire logic [liu_clk_pkg::BE_W-1:0]      byteenable,
	output var  logic [liu_clk_pkg::DATA_W-1:0]    readdata,
	output var  logic                              waitrequest,
	input  wire logic                              chan0_irq_in,
	output var  logic                              master_clock_out_pin,
	output var  logic [15:0]                       in_rate_khz_out,
	output var  logic                              in_rate_reserved,
	output var  logic                              irq
);
	import liu_clk_pkg::*;

	// One clock domain throughout; the pin rate comes from carry pulses
	// of a phase accumulator, never from a derived clock

	// Bus handshake state
	bus_state_t                state_r;
	bus_state_t                state_nxt;
	logic                      waitrequest_r;
	logic [DATA_W-1:0]         readdata_r;

	// Configuration and status storage
	logic [CFG_W-1:0]          out_cfg_r;
	logic [CFG_W-1:0]          out_cfg_nxt;
	logic [CFG_W-1:0]          in_cfg_r;
	logic [CFG_W-1:0]          in_cfg_nxt;
	logic                      chan0_irq_flag_r;
	logic                      chan0_irq_flag_nxt;
	logic                      chan0_seen_r;
	logic                      chan0_read_clr;
	logic                      irq_any;
	logic [EVT_W-1:0]          evt_status_r;
	logic [EVT_W-1:0]          evt_status_nxt;
	logic [EVT_W-1:0]          evt_enable_r;
	logic [EVT_W-1:0]          evt_enable_nxt;
	logic [EVT_W-1:0]          evt_set;
	logic                      irq_r;

	// Output clock synthesiser
	logic [NCO_W-1:0]          acc_r;
	logic [NCO_W-1:0]          acc_nxt;
	logic                      acc_carry;
	logic [NCO_W-1:0]          nco_step;
	logic                      clk_pin_r;

	// Input clock decode results
	logic [15:0]               in_khz_r;
	logic [15:0]               in_khz_dec;
	logic                      in_bad_r;

	// Field views
	logic [OUT_RATE_W-1:0]     out_clock_rate_sel;
	logic [IN_RATE_W-1:0]      in_clock_rate_sel;
	logic [IN_RATE_W-1:0]      in_sel_written;

	// Address and strobe decode
	logic                      req;
	logic                      req_start;
	logic                      done;
	logic [ADDR_W-3:0]         word;
	logic                      sel_out;
	logic                      sel_in;
	logic                      sel_gis;
	logic                      sel_evs;
	logic                      sel_evc;
	logic                      sel_eve;
	logic                      wr_lane0;
	logic                      wr_out;
	logic                      wr_in;
	logic                      wr_evc;
	logic                      wr_eve;
	logic                      rd_gis;
	logic [DATA_W-1:0]         rd_mux;
	logic [DATA_W-1:0]         rd_word_out;
	logic [DATA_W-1:0]         rd_word_in;
	logic [DATA_W-1:0]         rd_word_gis;
	logic [DATA_W-1:0]         rd_word_evs;
	logic [DATA_W-1:0]         rd_word_eve;

	// Request decode; one wait cycle, then the transfer completes.
	// Every request is answered the same way, so a master never
	// needs to know the map to know when its transfer ends.
	assign req       = read | write;
	assign req_start = req & (state_r == BUS_IDLE);
	assign done      = req & (state_r == BUS_ACK);

	// Handshake sequencing: idle until a request, then one acknowledge cycle.
	// The acknowledge state always falls back to idle, so a request held
	// past its acknowledge is taken again only as a fresh transfer.
	always_comb
	begin
		case (state_r)
			BUS_IDLE: state_nxt = req ? BUS_ACK : BUS_IDLE;
			BUS_ACK:  state_nxt = BUS_IDLE;
			default:  state_nxt = BUS_IDLE;
		endcase
	end

	// Word select; the low two address bits are ignored,
	// so every byte offset inside a word reaches the same register
	assign word    = address[ADDR_W-1:2];
	assign sel_out = (word == OFS_OUT_CFG[ADDR_W-1:2]);
	assign sel_in  = (word == OFS_IN_CFG[ADDR_W-1:2]);
	assign sel_gis = (word == OFS_GIS[ADDR_W-1:2]);
	assign sel_evs = (word == OFS_EVS[ADDR_W-1:2]);
	assign sel_evc = (word == OFS_EVC[ADDR_W-1:2]);
	assign sel_eve = (word == OFS_EVE[ADDR_W-1:2]);

	// Writes land only on the completing edge and only with lane 0 enabled;
	// a write with lane 0 off completes on the bus but changes nothing
	assign wr_lane0 = write & done & byteenable[0];
	assign wr_out   = wr_lane0 & sel_out;
	assign wr_in    = wr_lane0 & sel_in;
	assign wr_evc   = wr_lane0 & sel_evc;
	assign wr_eve   = wr_lane0 & sel_eve;
	assign rd_gis   = read & done & sel_gis;

	// Per-register read words, zero-extended to the bus width
	assign rd_word_out = {{(DATA_W-CFG_W){1'b0}}, out_cfg_r};
	assign rd_word_in  = {{(DATA_W-CFG_W){1'b0}}, in_cfg_r};
	assign rd_word_gis = {{(DATA_W-1){1'b0}}, chan0_irq_flag_r};
	assign rd_word_evs = {{(DATA_W-EVT_W){1'b0}}, evt_status_r};
	assign rd_word_eve = {{(DATA_W-EVT_W){1'b0}}, evt_enable_r};

	// Read mux; clear register and unmapped words read as zero,
	// so software probing the map never sees stale bus data
	assign rd_mux = sel_out ? rd_word_out :
	                sel_in  ? rd_word_in :
	                sel_gis ? rd_word_gis :
	                sel_evs ? rd_word_evs :
	                sel_eve ? rd_word_eve :
	                {DATA_W{1'b0}};

	// Configuration registers keep all eight bits, unused ones included;
	// reserved input codes are stored as written and flagged, not refused
	assign out_cfg_nxt = wr_out ? writedata[CFG_W-1:0] : out_cfg_r;
	assign in_cfg_nxt  = wr_in ? writedata[CFG_W-1:0] : in_cfg_r;

	// Field views of the stored configuration;
	// unused bits of both registers never reach the decode
	assign out_clock_rate_sel = out_cfg_r[OUT_RATE_LSB +: OUT_RATE_W];
	assign in_clock_rate_sel  = in_cfg_r[IN_RATE_LSB +: IN_RATE_W];
	assign in_sel_written     = writedata[IN_RATE_LSB +: IN_RATE_W];

	// Channel 0 flag: only a bit actually returned by a read is cleared,
	// so an event after the data was latched is never dropped. The data
	// is latched one edge before the clear, so an event seen at that
	// latching edge blocks the clear too: it is not in the returned bit.
	assign chan0_read_clr     = rd_gis & readdata_r[CHAN0_BIT] & ~chan0_seen_r;
	assign chan0_irq_flag_nxt = chan0_irq_in |
	                            (chan0_irq_flag_r & ~chan0_read_clr);

	// Event sources of the sticky status register
	assign evt_set[EVT_CHAN0]   = chan0_irq_in;
	assign evt_set[EVT_BAD_SEL] = wr_in & (in_rate_khz(in_sel_written) == KHZ_NONE);

	// Sticky event bits, write one to clear; a set in the same cycle wins,
	// so an event racing its own clear is reported again
	genvar gi;
	generate
		for (gi = 0; gi < EVT_W; gi = gi + 1)
		begin : g_evt
			assign evt_status_nxt[gi] = evt_set[gi] | (evt_status_r[gi] & ~(wr_evc & writedata[gi]));
		end
	endgenerate

	// Enable register written whole; a zero bit masks its event from irq
	assign evt_enable_nxt = wr_eve ? writedata[EVT_W-1:0] : evt_enable_r;

	// Any enabled event raises the level interrupt
	assign irq_any = |(evt_status_r & evt_enable_r);

	// Accumulator step chosen by the output rate field.
	// Steps are rounded down, so the pin runs slow by well under a part
	// per million; a wider accumulator would trade area for that error.
	assign nco_step = (out_clock_rate_sel == 2'h0) ? INC_1544 :
	                  (out_clock_rate_sel == 2'h1) ? INC_3088 :
	                  (out_clock_rate_sel == 2'h2) ? INC_6176 :
	                  INC_12352;

	// Carry out of the accumulator is the toggle enable pulse;
	// at most one carry per cycle, since every step is below full scale
	assign {acc_carry, acc_nxt} = {1'b0, acc_r} + {1'b0, nco_step};

	// Input rate decode; zero marks a reserved code.
	// Decoded from the stored field, so a reserved write shows one cycle after it is stored
	assign in_khz_dec = in_rate_khz(in_clock_rate_sel);

	// Bus handshake flops; waitrequest drops for exactly one cycle.
	// Registered so the bus sees a clean flop output, at the cost
	// of the fixed wait state on every transfer
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r       <= BUS_IDLE;
			waitrequest_r <= 1'b1;
		end
		else
		begin
			state_r       <= state_nxt;
			waitrequest_r <= (state_nxt != BUS_ACK);
		end
	end

	// Read data latched when the request is first seen, held through the ack.
	// Latching early keeps the word steady for the whole acknowledge
	// and fixes exactly which flag value a read will clear
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			readdata_r <= {DATA_W{1'b0}};
		else if (req_start && read)
			readdata_r <= rd_mux;
	end

	// Output rate configuration
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			out_cfg_r <= OUT_CFG_RST;
		else
			out_cfg_r <= out_cfg_nxt;
	end

	// Input rate configuration
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			in_cfg_r <= IN_CFG_RST;
		else
			in_cfg_r <= in_cfg_nxt;
	end

	// Channel 0 read-clear flag;
	// cleared only by a completed read of the status word
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			chan0_irq_flag_r <= 1'b0;
		else
			chan0_irq_flag_r <= chan0_irq_flag_nxt;
	end

	// Event level at the previous edge; at the completing edge of a read
	// this is the level seen when the returned data was latched
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			chan0_seen_r <= 1'b0;
		else
			chan0_seen_r <= chan0_irq_in;
	end

	// Sticky event status
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			evt_status_r <= {EVT_W{1'b0}};
		else
			evt_status_r <= evt_status_nxt;
	end

	// Event enables
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			evt_enable_r <= {EVT_W{1'b0}};
		else
			evt_enable_r <= evt_enable_nxt;
	end

	// Level interrupt, one cycle behind the status it reflects
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			irq_r <= 1'b0;
		else
			irq_r <= irq_any;
	end

	// Output clock: fractional divider, one toggle per carry.
	// Edges land on the 25 ns grid, so the pin carries up to one
	// system period of jitter; the average rate is exact to the step.
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			acc_r     <= {NCO_W{1'b0}};
			clk_pin_r <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			if (acc_carry)
				clk_pin_r <= ~clk_pin_r;
		end
	end

	// Registered input rate report; the device needs a valid input clock.
	// A reserved code reports zero kHz and raises the reserved flag
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			in_khz_r <= KHZ_1544;
			in_bad_r <= 1'b0;
		end
		else
		begin
			in_khz_r <= in_khz_dec;
			in_bad_r <= (in_khz_dec == KHZ_NONE);
		end
	end

	// Outputs straight from flops;
	// no output passes through logic, so pin timing stays simple
	assign readdata             = readdata_r;
	assign waitrequest          = waitrequest_r;
	assign master_clock_out_pin = clk_pin_r;
	assign in_rate_khz_out      = in_khz_r;
	assign in_rate_reserved     = in_bad_r;
	assign irq                  = irq_r;

endmodule

`default_nettype wire

// [liu_global_clock_irq_config_bench.sv]
// Self-checking bench for the line clock configuration block
`timescale 1ns/10ps
`default_nettype none
module liu_global_clock_irq_config_bench;
	import liu_clk_pkg::*;
	typedef struct {logic w; logic [7:0] a, d; logic [3:0] be; logic [7:0] e;} row_t;
	logic        clock, rstn, read, write, waitrequest, chan0_irq_in, pin, pv, in_rate_reserved, irq;
	logic [7:0]  address;
	logic [31:0] writedata, readdata, q;
	logic [3:0]  byteenable;
	logic [15:0] in_rate_khz_out;
	int          failures, comparisons, cycles, t;
	logic [15:0] kt[16] = '{KHZ_2048, KHZ_1544, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
		KHZ_4096, KHZ_3088, KHZ_8192, KHZ_6176, KHZ_16384, KHZ_12352, KHZ_2048, KHZ_1544};
	logic [15:0] ko[4] = '{KHZ_1544, KHZ_3088, KHZ_6176, KHZ_12352};
	// Transfer rows: write flag, address, data, byte enables, expected read
	row_t        rows[12] = '{'{1'h0, 8'h00, 8'h00, 4'hF, 8'h00}, '{1'h0, 8'h04, 8'h00, 4'hF, 8'h01},
		'{1'h0, 8'h08, 8'h00, 4'hF, 8'h00}, '{1'h1, 8'h00, 8'hC5, 4'hF, 8'h00},
		'{1'h0, 8'h00, 8'h00, 4'hF, 8'hC5}, '{1'h1, 8'h04, 8'h0E, 4'hF, 8'h00},
		'{1'h1, 8'h04, 8'h09, 4'hE, 8'h00}, '{1'h0, 8'h04, 8'h00, 4'hF, 8'h0E},
		'{1'h1, 8'h18, 8'hAB, 4'hF, 8'h00}, '{1'h0, 8'h18, 8'h00, 4'hF, 8'h00},
		'{1'h1, 8'h14, 8'h03, 4'hF, 8'h00}, '{1'h0, 8'h14, 8'h00, 4'hF, 8'h03}};
	liu_global_clock_irq_config u_dut (.clock, .rstn, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .chan0_irq_in, .master_clock_out_pin(pin),
		.in_rate_khz_out, .in_rate_reserved, .irq);
	host_model u_host (.clock, .waitrequest, .readdata, .address, .read, .write, .writedata,
		.byteenable);
	task automatic conclude;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, d, input logic [3:0] be, input logic [7:0] e);
		u_host.xfer(w, a, {24'h0, d}, be, q);
		if (!w)
			check("read data", {24'h0, e}, q);
	endtask
	// Free-running master clock
	initial
	begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end
	// Hang guard, well above the expected run
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			conclude();
		end
	end
	initial
	begin
		rstn = 1'h1;
		chan0_irq_in = 1'h0;
		#1 rstn = 1'h0; // Edge after time zero so every flop sees it
		repeat (3) @(posedge clock);
		rstn <= 1'h1;
		foreach (rows[i])
			acc(rows[i].w, rows[i].a, rows[i].d, rows[i].be, rows[i].e);
		// Every input code, reserved ones raise an event
		for (t = 0; t < 16; t++)
		begin
			acc(1'h1, OFS_IN_CFG, 8'(t), 4'hF, 8'h00);
			repeat (2) @(negedge clock);
			check("input rate", {16'h0, kt[t]}, {16'h0, in_rate_khz_out});
		end
		check("irq raised", 32'h1, {31'h0, irq});
		acc(1'h0, OFS_EVS, 8'h00, 4'hF, 8'h02);
		acc(1'h1, OFS_EVE, 8'h00, 4'hF, 8'h00);
		repeat (2) @(negedge clock);
		check("irq masked", 32'h0, {31'h0, irq});
		acc(1'h1, OFS_EVE, 8'h03, 4'hF, 8'h00);
		acc(1'h1, OFS_EVC, 8'h03, 4'hF, 8'h00);
		repeat (2) @(negedge clock);
		check("irq cleared", 32'h0, {31'h0, irq});
		// Sticky flag, then an event held across the read itself
		@(posedge clock);
		chan0_irq_in <= 1'h1;
		@(posedge clock);
		chan0_irq_in <= 1'h0;
		acc(1'h0, OFS_GIS, 8'h00, 4'hF, 8'h01);
		acc(1'h0, OFS_GIS, 8'h00, 4'hF, 8'h00);
		chan0_irq_in <= 1'h1;
		acc(1'h0, OFS_GIS, 8'h00, 4'hF, 8'h01);
		chan0_irq_in <= 1'h0;
		acc(1'h0, OFS_GIS, 8'h00, 4'hF, 8'h01);
		acc(1'h0, OFS_GIS, 8'h00, 4'hF, 8'h00);
		// Flag set, then an event only at the edge the read is taken
		@(posedge clock);
		chan0_irq_in <= 1'h1;
		@(posedge clock);
		chan0_irq_in <= 1'h0;
		fork
			acc(1'h0, OFS_GIS, 8'h00, 4'hF, 8'h01);
			begin
				@(posedge clock);
				chan0_irq_in <= 1'h1;
				@(posedge clock);
				chan0_irq_in <= 1'h0;
			end
		join
		acc(1'h0, OFS_GIS, 8'h00, 4'hF, 8'h01);
		acc(1'h0, OFS_GIS, 8'h00, 4'hF, 8'h00);
		// Toggle count over 1000 cycles, jitter allowed one toggle
		for (int r = 0; r < 4; r++)
		begin
			acc(1'h1, OFS_OUT_CFG, 8'(r << 4), 4'hF, 8'h00);
			t = 0;
			@(negedge clock);
			pv = pin;
			repeat (1000)
			begin
				@(negedge clock);
				t += int'(pin != pv);
				pv = pin;
			end
			check("clock rate", 32'h1, {31'h0, t * 20 + 20 >= ko[r] && t * 20 <= ko[r] + 20});
		end
		@(posedge clock);
		rstn <= 1'h0;
		repeat (3) @(posedge clock);
		rstn <= 1'h1;
		acc(1'h0, OFS_OUT_CFG, 8'h00, 4'hF, 8'h00);
		acc(1'h0, OFS_IN_CFG, 8'h00, 4'hF, 8'h01);
		conclude();
	end
endmodule
`default_nettype wire
